// ### darss_top.sv
// Purpose: Auto restart supervisor of a motor drive after a trip
// Assumes: fault_in and sec_tick come from logic on the same clock
// Notes:   Keypad stop and emergency stop are pins, synchronised here
//
// How it works
// [RQ1] Restart limit 0 to 5, zero disables
// [RQ2] Window 300 to 65535 s from first restart
// [RQ3] Limit reached: latch fault, no more restarts
// [RQ4] Keypad stop press clears the latched fault
// [RQ5] Emergency stop never clears the latched fault
// [RQ6] Window lapsed below limit: clear count, timer
// [RQ7] Wait 3 to 60 s delay before restart
// [RQ8] Four starting modes, normal after reset
// [RQ9] Line start modes need confirmation before use
// [RQ10] Count attempts, window starts first, ticks seconds
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module darss_top (
   input wire logic clock,          // 100 MHz system clock
   input wire logic rstn,           // Asynchronous reset, active low
   input wire logic [3:0] addr,     // Register word address
   input wire logic [15:0] wdata,   // Register write data
   input wire logic wr_en,          // Write strobe
   input wire logic rd_en,          // Read strobe
   output logic [15:0] rdata_r,     // Read data, cycle after strobe
   input wire logic fault_in,       // Drive tripped, level
   input wire logic sec_tick,       // One-second tick, one cycle
   input wire logic keypad_stop,    // Keypad stop key pin
   input wire logic estop,          // Emergency stop pin
   output logic restart_req_r,      // Restart attempt, one cycle
   output logic latched_r,          // Latched fault, manual reset needed
   output logic [1:0] mode_r,       // Active starting mode
   output logic irq_r               // Interrupt, level
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Clamps a written value into its legal range
   function automatic logic [15:0] clamp16(input logic [15:0] v,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi);
      logic [15:0] r;
      r = v;
      if (v < lo) begin
         r = lo;
      end else if (v > hi) begin
         r = hi;
      end
      return r;
   endfunction

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [1:0] s1_r, s2_r, s3_r, filt_r; // Bit 0 stop, bit 1 estop
   logic [1:0] filt_nxt; // Filtered level next
   logic [1:0] agree; // Stages two and three agree
   logic stop_rise; // Keypad stop press

   // Filter takes a level once two later stages agree
   always_comb begin
      agree = ~(s2_r ^ s3_r);
      filt_nxt = (agree & s2_r) | (~agree & filt_r);
      stop_rise = filt_nxt[0] & ~filt_r[0];
   end

   // Synchroniser stages
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s1_r <= 2'h0;
         s2_r <= 2'h0;
         s3_r <= 2'h0;
         filt_r <= 2'h0;
      end else begin
         s1_r <= {estop, keypad_stop};
         s2_r <= s1_r;
         s3_r <= s2_r;
         filt_r <= filt_nxt;
      end
   end

   // ****************************************************************
   // Supervisor state and registers
   // ****************************************************************
   darss_pkg::darss_state_t state_r, state_nxt; // Supervisor state
   logic [2:0] tries_r, tries_nxt; // Attempt limit
   logic [15:0] window_r, window_nxt; // Window length, seconds
   logic [5:0] delay_r, delay_nxt; // Restart delay, seconds
   logic [2:0] count_r, count_nxt; // Attempts inside window
   logic [16:0] win_cnt_r, win_cnt_nxt; // Seconds since first restart
   logic win_run_r, win_run_nxt; // Window running
   logic [5:0] dly_cnt_r, dly_cnt_nxt; // Seconds since fault
   logic fault_prev_r; // Fault level last cycle
   logic fault_rise; // New trip
   logic restart_nxt, latched_nxt, irq_nxt; // Output next values
   logic [1:0] mode_nxt, pend_r, pend_nxt; // Mode and pending mode
   logic prompt_r, prompt_nxt; // Confirmation awaited
   logic [2:0] stat_r, stat_nxt, mask_r, mask_nxt; // Event registers
   logic [2:0] ev; // Events this cycle
   logic [15:0] rdata_nxt, status_word; // Read path
   logic [15:0] cl_tries, cl_window, cl_delay; // Clamped writes

   assign cl_tries = clamp16(wdata, darss_pkg::TRIES_MIN,
                             darss_pkg::TRIES_MAX);
   assign cl_window = clamp16(wdata, darss_pkg::WINDOW_MIN,
                              darss_pkg::WINDOW_MAX);
   assign cl_delay = clamp16(wdata, darss_pkg::DELAY_MIN,
                             darss_pkg::DELAY_MAX);

   // Next values of sequencing, configuration, events and read data
   always_comb begin
      fault_rise = fault_in & ~fault_prev_r;
      state_nxt = state_r;
      count_nxt = count_r;
      win_cnt_nxt = win_cnt_r;
      win_run_nxt = win_run_r;
      dly_cnt_nxt = dly_cnt_r;
      restart_nxt = 1'b0;
      ev = 3'h0;
      tries_nxt = tries_r;
      window_nxt = window_r;
      delay_nxt = delay_r;
      mode_nxt = mode_r;
      pend_nxt = pend_r;
      prompt_nxt = prompt_r;
      mask_nxt = mask_r;
      rdata_nxt = 16'h0000;

      // Window advances once a second while running
      if (win_run_r && sec_tick && win_cnt_r != darss_pkg::WIN_SAT) begin
         win_cnt_nxt = win_cnt_r + 17'h00001; // see [RQ10]
      end
      // Lapsed window below the limit starts afresh
      if (win_run_r && win_cnt_r > {1'b0, window_r} &&
          count_r < tries_r) begin
         count_nxt = 3'h0; // see [RQ6]
         win_cnt_nxt = 17'h00000;
         win_run_nxt = 1'b0;
         ev[darss_pkg::EV_LAPSE] = 1'b1;
      end

      case (state_r)
         darss_pkg::st_idle: begin
            // Trip: restart if attempts remain, else latch
            if (fault_rise) begin
               if (tries_r == 3'h0 || count_nxt >= tries_r) begin
                  state_nxt = darss_pkg::st_latched; // see [RQ1] [RQ3]
                  ev[darss_pkg::EV_LATCH] = 1'b1;
               end else begin
                  state_nxt = darss_pkg::st_delay; // see [RQ7]
                  dly_cnt_nxt = 6'h00;
               end
            end
         end
         darss_pkg::st_delay: begin
            // Delay counted in seconds, then one restart attempt
            if (dly_cnt_r >= delay_r) begin
               restart_nxt = 1'b1; // see [RQ7]
               ev[darss_pkg::EV_RESTART] = 1'b1;
               state_nxt = darss_pkg::st_idle;
               if (count_nxt == 3'h0) begin
                  win_run_nxt = 1'b1; // see [RQ2] [RQ10]
                  win_cnt_nxt = 17'h00000;
               end
               count_nxt = count_nxt + 3'h1; // see [RQ10]
            end else if (sec_tick) begin
               dly_cnt_nxt = dly_cnt_r + 6'h01;
            end
         end
         darss_pkg::st_latched: begin
            // Only the keypad stop resets; emergency stop is ignored
            if (stop_rise) begin
               state_nxt = darss_pkg::st_idle; // see [RQ4] [RQ5]
               count_nxt = 3'h0;
               win_cnt_nxt = 17'h00000;
               win_run_nxt = 1'b0;
            end
         end
         default: begin
            state_nxt = darss_pkg::st_idle;
         end
      endcase
      latched_nxt = (state_nxt == darss_pkg::st_latched); // see [RQ3]

      // Register writes
      if (wr_en) begin
         if (addr == darss_pkg::ADDR_TRIES) begin
            tries_nxt = cl_tries[2:0]; // see [RQ1]
         end else if (addr == darss_pkg::ADDR_WINDOW) begin
            window_nxt = cl_window; // see [RQ2]
         end else if (addr == darss_pkg::ADDR_DELAY) begin
            delay_nxt = cl_delay[5:0]; // see [RQ7]
         end else if (addr == darss_pkg::ADDR_MODE) begin
            // Line start choices wait for confirmation
            if (wdata[1:0] == darss_pkg::mode_line_start ||
                wdata[1:0] == darss_pkg::autostart_and_catch_mode) begin
               pend_nxt = wdata[1:0]; // see [RQ9]
               prompt_nxt = 1'b1;
            end else begin
               mode_nxt = wdata[1:0]; // see [RQ8]
               prompt_nxt = 1'b0;
            end
         end else if (addr == darss_pkg::ADDR_CONFIRM) begin
            // One confirms, zero abandons the change
            if (prompt_r && wdata[0]) begin
               mode_nxt = pend_r; // see [RQ9]
            end
            prompt_nxt = 1'b0;
         end else if (addr == darss_pkg::ADDR_IRQ_MASK) begin
            mask_nxt = wdata[2:0];
         end
      end

      // Sticky events: a new event beats a clear
      stat_nxt = stat_r;
      if (wr_en && addr == darss_pkg::ADDR_IRQ_STAT) begin
         stat_nxt = stat_r & ~wdata[2:0];
      end
      stat_nxt = stat_nxt | ev;
      irq_nxt = |(stat_nxt & mask_nxt);

      // Live status word
      status_word = 16'h0000;
      status_word[2:0] = count_r;
      status_word[darss_pkg::ST_LATCHED] = latched_r;
      status_word[darss_pkg::ST_WAITING] = (state_r == darss_pkg::st_delay);
      status_word[darss_pkg::ST_WIN_RUN] = win_run_r;
      status_word[darss_pkg::ST_PROMPT] = prompt_r;

      // Read decode; unmapped reads return zero
      if (rd_en) begin
         if (addr == darss_pkg::ADDR_TRIES) begin
            rdata_nxt = {13'h0000, tries_r};
         end else if (addr == darss_pkg::ADDR_WINDOW) begin
            rdata_nxt = window_r;
         end else if (addr == darss_pkg::ADDR_DELAY) begin
            rdata_nxt = {10'h000, delay_r};
         end else if (addr == darss_pkg::ADDR_MODE) begin
            rdata_nxt = {12'h000, pend_r, mode_r};
         end else if (addr == darss_pkg::ADDR_STATUS) begin
            rdata_nxt = status_word;
         end else if (addr == darss_pkg::ADDR_IRQ_STAT) begin
            rdata_nxt = {13'h0000, stat_r};
         end else if (addr == darss_pkg::ADDR_IRQ_MASK) begin
            rdata_nxt = {13'h0000, mask_r};
         end
      end
   end

   // Registers of the supervisor
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_r <= darss_pkg::st_idle;
         tries_r <= darss_pkg::TRIES_RST;
         window_r <= darss_pkg::WINDOW_RST;
         delay_r <= darss_pkg::DELAY_RST;
         count_r <= 3'h0;
         win_cnt_r <= 17'h00000;
         win_run_r <= 1'b0;
         dly_cnt_r <= 6'h00;
         fault_prev_r <= 1'b0;
         restart_req_r <= 1'b0;
         latched_r <= 1'b0;
         mode_r <= darss_pkg::mode_normal;
         pend_r <= darss_pkg::mode_normal;
         prompt_r <= 1'b0;
         stat_r <= 3'h0;
         mask_r <= 3'h0;
         irq_r <= 1'b0;
         rdata_r <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         tries_r <= tries_nxt;
         window_r <= window_nxt;
         delay_r <= delay_nxt;
         count_r <= count_nxt;
         win_cnt_r <= win_cnt_nxt;
         win_run_r <= win_run_nxt;
         dly_cnt_r <= dly_cnt_nxt;
         fault_prev_r <= fault_in;
         restart_req_r <= restart_nxt;
         latched_r <= latched_nxt;
         mode_r <= mode_nxt;
         pend_r <= pend_nxt;
         prompt_r <= prompt_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         irq_r <= irq_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence trip_with_room;
      state_r == darss_pkg::st_idle && fault_rise && tries_r != 3'h0 &&
      count_r < tries_r && !(win_run_r && win_cnt_r > {1'b0, window_r});
   endsequence

   sequence delay_done;
      state_r == darss_pkg::st_delay && dly_cnt_r >= delay_r;
   endsequence

   limit_range_a: assert property ( // see [RQ1]
      {13'h0, tries_r} <= darss_pkg::TRIES_MAX)
      else $error("restart limit above five");
   window_range_a: assert property ( // see [RQ2]
      window_r >= darss_pkg::WINDOW_MIN)
      else $error("window below 300 s");
   trip_latch_a: assert property ( // see [RQ3]
      state_r == darss_pkg::st_idle && fault_rise &&
      count_r >= tries_r |=> latched_r && !restart_req_r)
      else $error("exhausted trip did not latch");
   stop_reset_a: assert property ( // see [RQ4]
      latched_r && stop_rise |=> !latched_r && count_r == 3'h0)
      else $error("stop press did not clear latch");
   estop_ignored_a: assert property ( // see [RQ5]
      latched_r && !stop_rise |=> latched_r)
      else $error("latch cleared without stop press");
   lapse_clear_a: assert property ( // see [RQ6]
      win_run_r && win_cnt_r > {1'b0, window_r} && count_r < tries_r &&
      state_r != darss_pkg::st_delay |=> count_r == 3'h0 && !win_run_r)
      else $error("lapsed window not cleared");
   delay_start_a: assert property ( // see [RQ7]
      trip_with_room |=> state_r == darss_pkg::st_delay ##0
      !restart_req_r)
      else $error("trip did not enter delay");
   restart_seq_a: assert property ( // see [RQ7] [RQ10]
      delay_done |=> restart_req_r ##1 !restart_req_r)
      else $error("restart pulse wrong");
   restart_cause_a: assert property ( // see [RQ7]
      $rose(restart_req_r) |-> $past(dly_cnt_r) >= $past(delay_r))
      else $error("restart before delay ended");
   count_step_a: assert property ( // see [RQ10]
      restart_req_r |-> win_run_r && count_r != 3'h0)
      else $error("attempt not counted");
   mode_hold_a: assert property ( // see [RQ9]
      wr_en && addr == darss_pkg::ADDR_MODE &&
      wdata[1:0] == darss_pkg::mode_line_start
      |=> prompt_r && mode_r == $past(mode_r))
      else $error("line start applied unconfirmed");
   mode_confirm_a: assert property ( // see [RQ8] [RQ9]
      wr_en && addr == darss_pkg::ADDR_CONFIRM && wdata[0] && prompt_r
      |=> mode_r == $past(pend_r) && !prompt_r)
      else $error("confirmed mode not applied");
   irq_level_a: assert property (
      irq_r == |(stat_r & mask_r))
      else $error("interrupt level wrong");

endmodule
`default_nettype wire

// ### darss_pkg.sv
// Purpose: Constants and types of the drive auto restart supervisor
// Assumes: 16-bit register data, 4-bit word addresses
// Notes:   All times are whole seconds counted on the seconds tick
`default_nettype none
package darss_pkg;

   // ****************************************************************
   // Bus shape
   // ****************************************************************
   localparam int DATA_W = 16;                 // Register data width
   localparam int ADDR_W = 4;                  // Register address width

   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [3:0] ADDR_TRIES = 4'h0;   // Restart attempt limit
   localparam logic [3:0] ADDR_WINDOW = 4'h1;  // Restart window, seconds
   localparam logic [3:0] ADDR_DELAY = 4'h2;   // Restart delay, seconds
   localparam logic [3:0] ADDR_MODE = 4'h3;    // Starting mode
   localparam logic [3:0] ADDR_CONFIRM = 4'h4; // Mode change confirmation
   localparam logic [3:0] ADDR_STATUS = 4'h5;  // Live supervisor state
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h6; // Sticky events, W1C
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h7; // Event enables

   // ****************************************************************
   // Limits and reset values
   // ****************************************************************
   localparam logic [15:0] TRIES_MIN = 16'h0000;  // No auto restart
   localparam logic [15:0] TRIES_MAX = 16'h0005;  // Most attempts
   localparam logic [2:0] TRIES_RST = 3'h0;       // Disabled at reset
   localparam logic [15:0] WINDOW_MIN = 16'h012C; // 300 s
   localparam logic [15:0] WINDOW_MAX = 16'hFFFF; // 65535 s
   localparam logic [15:0] WINDOW_RST = 16'h012C; // 300 s
   localparam logic [15:0] DELAY_MIN = 16'h0003;  // 3 s
   localparam logic [15:0] DELAY_MAX = 16'h003C;  // 60 s
   localparam logic [5:0] DELAY_RST = 6'h05;      // 5 s
   localparam logic [16:0] WIN_SAT = 17'h1FFFF;   // Window count ceiling

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int ST_LATCHED = 3;   // Status: latched fault
   localparam int ST_WAITING = 4;   // Status: restart delay running
   localparam int ST_WIN_RUN = 5;   // Status: window running
   localparam int ST_PROMPT = 6;    // Status: mode change awaits confirm
   localparam int EV_RESTART = 0;   // Event: restart issued
   localparam int EV_LATCH = 1;     // Event: fault latched
   localparam int EV_LAPSE = 2;     // Event: window lapsed
   localparam int EV_W = 3;         // Number of events

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      mode_normal,
      mode_line_start,
      mode_catch_rotating,
      autostart_and_catch_mode
   } darss_mode_t;

   typedef enum logic [1:0] {
      st_idle,
      st_delay,
      st_latched
   } darss_state_t;

endpackage
`default_nettype wire

// ### darss_drive_model.sv
// Purpose: Far side of the restart supervisor: drive trips, tick, keys
// Assumes: Driven on the rising clock edge, same clock as the block
// Notes:   Keys are held a few cycles so the pin synchronisers see them
`timescale 1ns/10ps
`default_nettype none
module darss_drive_model #(
   parameter int TICK_DIV = 4 // Clock cycles per simulated second
) (
   input wire logic clock, // System clock
   input wire logic rstn, // Reset, active low
   output logic fault_in, // Drive tripped
   output logic sec_tick, // One-second tick
   output logic keypad_stop, // Keypad stop key pin
   output logic estop // Emergency stop pin
);
   // ****************************************************************
   // Seconds tick
   // ****************************************************************
   int div_r; // Tick divider

   initial begin
      fault_in = 1'b0;
      keypad_stop = 1'b0;
      estop = 1'b0;
   end

   // Free-running tick, one cycle in every TICK_DIV
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         div_r <= 0;
         sec_tick <= 1'b0;
      end else begin
         div_r <= (div_r == TICK_DIV - 1) ? 0 : div_r + 1;
         sec_tick <= (div_r == TICK_DIV - 1);
      end
   end

   // ****************************************************************
   // Operator and drive actions
   // ****************************************************************
   // One trip: fault rises for one cycle, then clears
   task automatic trip();
      @(posedge clock);
      fault_in <= 1'b1;
      @(posedge clock);
      fault_in <= 1'b0;
   endtask

   // Press and release a key; sel 1 keypad stop, 0 emergency stop
   task automatic press(input bit sel);
      @(posedge clock);
      if (sel) begin
         keypad_stop <= 1'b1; // Manual reset key
      end else begin
         estop <= 1'b1; // Emergency stop only
      end
      repeat (6) @(posedge clock);
      keypad_stop <= 1'b0;
      estop <= 1'b0;
      repeat (6) @(posedge clock);
   endtask
endmodule
`default_nettype wire

// ### darss_top_test.sv
// Purpose: Self-checking bench of the drive auto restart supervisor
// Assumes: One second is TICK_DIV clock cycles
// Notes:   Registers are reached through the plain strobe port
`timescale 1ns/10ps
`default_nettype none
module darss_top_test;
   // ****************************************************************
   // Signals
   // ****************************************************************
   localparam int TICK_DIV = 4; // Cycles per second
   logic clock = 1'b0; // System clock
   logic rstn = 1'b0; // Reset, active low
   logic [3:0] addr = 4'h0; // Register address
   logic [15:0] wdata = 16'h0000; // Write data
   logic wr_en = 1'b0; // Write strobe
   logic rd_en = 1'b0; // Read strobe
   logic [15:0] rdata_r; // Read data
   logic fault_in, sec_tick, keypad_stop, estop; // Far side pins
   logic restart_req_r, latched_r, irq_r; // Supervisor outputs
   logic [1:0] mode_r; // Active mode
   logic [15:0] rv; // Read result
   int miscompares = 0; // Mismatch count
   int tests_run = 0; // Comparison count
   int n; // Cycle count

   always #5 clock = ~clock;

   darss_top dut_u (.clock(clock), .rstn(rstn), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_r(rdata_r),
      .fault_in(fault_in), .sec_tick(sec_tick),
      .keypad_stop(keypad_stop), .estop(estop),
      .restart_req_r(restart_req_r), .latched_r(latched_r),
      .mode_r(mode_r), .irq_r(irq_r));

   darss_drive_model #(.TICK_DIV(TICK_DIV)) drv_u (.clock(clock),
      .rstn(rstn), .fault_in(fault_in), .sec_tick(sec_tick),
      .keypad_stop(keypad_stop), .estop(estop));

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1;
      d = rdata_r;
   endtask

   // Bounded wait for a restart pulse, cycles counted in n
   task automatic wait_restart();
      n = 0;
      while (restart_req_r !== 1'b1) begin
         @(posedge clock);
         #1;
         n++;
         if (n > 300) begin
            miscompares++;
            finish_test();
         end
      end
   endtask

   // Bounded wait for the latched fault to clear
   task automatic wait_unlatch();
      n = 0;
      while (latched_r !== 1'b0) begin
         @(posedge clock);
         #1;
         n++;
         if (n > 30) begin
            miscompares++;
            finish_test();
         end
      end
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   // Reset values, clamping and an unmapped address
   task automatic t_regs();
      rd(darss_pkg::ADDR_TRIES, rv);
      check(rv, 16'h0000);
      rd(darss_pkg::ADDR_WINDOW, rv);
      check(rv, 16'h012C);
      rd(darss_pkg::ADDR_DELAY, rv);
      check(rv, 16'h0005);
      rd(darss_pkg::ADDR_MODE, rv);
      check(rv, 16'h0000);
      rd(4'h8, rv);
      check(rv, 16'h0000);
      wr(darss_pkg::ADDR_TRIES, 16'h0007);
      rd(darss_pkg::ADDR_TRIES, rv);
      check(rv, 16'h0005);
      wr(darss_pkg::ADDR_WINDOW, 16'h0010);
      rd(darss_pkg::ADDR_WINDOW, rv);
      check(rv, 16'h012C);
      wr(darss_pkg::ADDR_DELAY, 16'h0040);
      rd(darss_pkg::ADDR_DELAY, rv);
      check(rv, 16'h003C);
      wr(darss_pkg::ADDR_DELAY, 16'h0001);
      rd(darss_pkg::ADDR_DELAY, rv);
      check(rv, 16'h0003);
   endtask

   // Zero tries latches at once; only the keypad clears it
   task automatic t_zero_tries();
      wr(darss_pkg::ADDR_TRIES, 16'h0000);
      drv_u.trip();
      repeat (3) @(posedge clock);
      #1;
      check({15'h0, latched_r}, 16'h0001);
      drv_u.press(1'b0);
      check({15'h0, latched_r}, 16'h0001);
      drv_u.press(1'b1);
      wait_unlatch();
      check({15'h0, latched_r}, 16'h0000);
   endtask

   // Delay, counting, interrupt and exhaustion of the limit
   task automatic t_limit();
      wr(darss_pkg::ADDR_TRIES, 16'h0002);
      wr(darss_pkg::ADDR_IRQ_STAT, 16'h0007);
      wr(darss_pkg::ADDR_IRQ_MASK, 16'h0007);
      drv_u.trip();
      wait_restart();
      check({15'h0, n >= 9 && n <= 15}, 16'h0001);
      repeat (2) @(posedge clock);
      #1;
      check({15'h0, irq_r}, 16'h0001);
      rd(darss_pkg::ADDR_STATUS, rv);
      check(rv & 16'h0027, 16'h0021);
      wr(darss_pkg::ADDR_IRQ_STAT, 16'h0001);
      repeat (2) @(posedge clock);
      #1;
      check({15'h0, irq_r}, 16'h0000);
      drv_u.trip();
      wait_restart();
      @(posedge clock);
      rd(darss_pkg::ADDR_STATUS, rv);
      check(rv & 16'h0007, 16'h0002);
      drv_u.trip();
      repeat (3) @(posedge clock);
      #1;
      check({15'h0, latched_r}, 16'h0001);
      rd(darss_pkg::ADDR_IRQ_STAT, rv);
      check(rv & 16'h0002, 16'h0002);
      drv_u.trip();
      repeat (20 * TICK_DIV) @(posedge clock);
      rd(darss_pkg::ADDR_STATUS, rv);
      check(rv & 16'h000F, 16'h000A);
      drv_u.press(1'b1);
      wait_unlatch();
      check({15'h0, latched_r}, 16'h0000);
      wr(darss_pkg::ADDR_IRQ_STAT, 16'h0007);
   endtask

   // Window lapse below the limit clears count and timer
   task automatic t_window();
      drv_u.trip();
      wait_restart();
      repeat (290 * TICK_DIV) @(posedge clock);
      rd(darss_pkg::ADDR_STATUS, rv);
      check(rv & 16'h0027, 16'h0021);
      repeat (20 * TICK_DIV) @(posedge clock);
      rd(darss_pkg::ADDR_STATUS, rv);
      check(rv & 16'h0027, 16'h0000);
      rd(darss_pkg::ADDR_IRQ_STAT, rv);
      check(rv & 16'h0004, 16'h0004);
   endtask

   // Starting modes; line start kinds wait for confirmation
   task automatic t_modes();
      wr(darss_pkg::ADDR_MODE, 16'h0001);
      check({14'h0, mode_r}, 16'h0000);
      rd(darss_pkg::ADDR_STATUS, rv);
      check(rv & 16'h0040, 16'h0040);
      wr(darss_pkg::ADDR_CONFIRM, 16'h0001);
      check({14'h0, mode_r}, 16'h0001);
      wr(darss_pkg::ADDR_MODE, 16'h0002);
      check({14'h0, mode_r}, 16'h0002);
      wr(darss_pkg::ADDR_MODE, 16'h0003);
      wr(darss_pkg::ADDR_CONFIRM, 16'h0000);
      check({14'h0, mode_r}, 16'h0002);
      wr(darss_pkg::ADDR_MODE, 16'h0003);
      wr(darss_pkg::ADDR_CONFIRM, 16'h0001);
      check({14'h0, mode_r}, 16'h0003);
      wr(darss_pkg::ADDR_MODE, 16'h0000);
      check({14'h0, mode_r}, 16'h0000);
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      t_regs();
      t_zero_tries();
      t_limit();
      t_window();
      t_modes();
      finish_test();
   end
endmodule
`default_nettype wire
